// ==== core/pad_regs_pkg.sv ====
// Constants shared by the pad output register block and its capture cell.
// Assumes one 200 MHz clock, aclk, and 32-bit AXI4-Lite register access.
package pad_regs_pkg;

    // ------------------------------------------------------------
    // Bus and data widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PAD_W = 16;
    localparam int unsigned NUM_VARIANTS = 8;

    // ------------------------------------------------------------
    // Register map, fields and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DATA_BASE = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h20;
    localparam logic [7:0] OFS_CONFIG = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam int unsigned FLD_READBACK_LSB = 16;
    localparam int unsigned FLD_POLARITY = 0;
    localparam int unsigned FLD_STS_INIT = 0;
    localparam int unsigned FLD_STS_CLEAR_N = 1;
    localparam logic [7:0] ENABLE_RST = 8'hFF;
    localparam logic POLARITY_RST = 1'b1;
    localparam logic PAD_PRESET_LEVEL = 1'b1;
    localparam logic PAD_CLEAR_LEVEL = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Variant table, index = register slot
    // ------------------------------------------------------------
    localparam int unsigned VAR_WIDTH [NUM_VARIANTS] = '{1, 1, 4, 8, 16, 1, 1, 1};
    localparam bit VAR_NEG_EDGE [NUM_VARIANTS] = '{1, 0, 0, 0, 0, 1, 0, 1};
    localparam bit VAR_PRESET [NUM_VARIANTS] = '{1, 0, 0, 0, 0, 0, 1, 1};
    localparam bit VAR_TRISTATE [NUM_VARIANTS] = '{0, 1, 1, 1, 1, 1, 1, 1};
    localparam logic [15:0] VAR_MASK [NUM_VARIANTS] = '{
        16'h0001, 16'h0001, 16'h000F, 16'h00FF,
        16'hFFFF, 16'h0001, 16'h0001, 16'h0001
    };

endpackage : pad_regs_pkg

// ==== core/pad_capture_register.sv ====
// One pad output register: a row of D flip-flops with an optional shared
// active-low three-state enable. Assumes init_async is already qualified
// for the active level that the owner has chosen.
`timescale 1ns/10ps
module pad_capture_register
    import pad_regs_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter bit NEG_EDGE = 1'b0,
    parameter bit PRESET = 1'b0,
    parameter bit HAS_TRISTATE = 1'b1
) (
    input wire logic clk,
    input wire logic aresetn,
    input wire logic init_async,
    input wire logic [WIDTH-1:0] data,
    input wire logic enable_n,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe
);

    localparam logic [WIDTH-1:0] INIT_VALUE =
        {WIDTH{PRESET ? PAD_PRESET_LEVEL : PAD_CLEAR_LEVEL}};

    logic [WIDTH-1:0] q_q;
    logic [WIDTH-1:0] q_d;
    logic [WIDTH-1:0] oe_q;
    logic [WIDTH-1:0] oe_d;

    // ------------------------------------------------------------
    // Data flip-flops
    // ------------------------------------------------------------
    always_comb begin
        q_d = aresetn ? data : INIT_VALUE;
    end

    // Capture goes on regardless of the enable, so a value written while
    // the pin floats is the one that appears when it is driven again.
    generate
        if (NEG_EDGE) begin : g_fall
            always_ff @(negedge clk or posedge init_async) begin
                if (init_async) begin
                    q_q <= INIT_VALUE;
                end else begin
                    q_q <= q_d;
                end
            end
        end else begin : g_rise
            always_ff @(posedge clk or posedge init_async) begin
                if (init_async) begin
                    q_q <= INIT_VALUE;
                end else begin
                    q_q <= q_d;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Output enable
    // ------------------------------------------------------------
    always_comb begin
        if (!HAS_TRISTATE) begin
            oe_d = '1;
        end else if (!aresetn) begin
            oe_d = '0;
        end else begin
            oe_d = {WIDTH{~enable_n}};
        end
    end

    always_ff @(posedge clk) begin
        oe_q <= oe_d;
    end

    assign pin_out = q_q;
    assign pin_oe = oe_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!aresetn);

    a_init_forces_value: assert property (init_async |-> pin_out == INIT_VALUE)
        else $error("pad register not forced to its initial value");

    generate
        if (NEG_EDGE) begin : g_chk_fall
            a_fall_capture: assert property (
                !init_async && !$past(init_async) |-> pin_out == data)
                else $error("falling-edge capture missed the data");
        end else begin : g_chk_rise
            a_rise_capture: assert property (
                !init_async && !$past(init_async) && $past(aresetn)
                |-> pin_out == $past(data))
                else $error("rising-edge capture missed the data");
        end
        if (HAS_TRISTATE) begin : g_chk_oe
            a_oe_tracks_enable: assert property (
                $past(aresetn) |-> pin_oe == {WIDTH{!$past(enable_n)}})
                else $error("output enable does not follow the enable bit");
        end else begin : g_chk_drive
            a_always_drives: assert property (pin_oe == '1)
                else $error("unbuffered pad stopped driving");
        end
    endgenerate

endmodule : pad_capture_register

// ==== core/pad_output_register_tristate.sv ====
// Pad output register bank behind an AXI4-Lite register slave.
// Assumes a single 200 MHz aclk, synchronous active-low aresetn, and that
// global_init and global_clear_n arrive straight from pins.
//
// Overview of operation
// - Inverted-clock preset pad captures on falling edge.
// - Preset variants forced high by global init.
// - Global init active level is software selectable.
// - Clear variants forced low by either init.
// - Global clear input is active low.
// - Default three-state variants capture on rising edge.
// - Enable low drives pad from flip-flop.
// - Enable high floats every three-state pad output.
// - Three-state variants in widths 1, 4, 8, 16.
// - Inverted-clock three-state variants capture on falling edge.
// - Preset three-state variant: rising edge, starts high.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module pad_output_register_tristate
    import pad_regs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    input wire logic global_init,
    input wire logic global_clear_n,
    output logic preset_negedge_pin,
    output logic tri_pin_1,
    output logic tri_pin_1_oe,
    output logic [3:0] tri_pin_4,
    output logic [3:0] tri_pin_4_oe,
    output logic [7:0] tri_pin_8,
    output logic [7:0] tri_pin_8_oe,
    output logic [15:0] tri_pin_16,
    output logic [15:0] tri_pin_16_oe,
    output logic tri_negedge_pin,
    output logic tri_negedge_pin_oe,
    output logic tri_preset_pin,
    output logic tri_preset_pin_oe,
    output logic tri_preset_negedge_pin,
    output logic tri_preset_negedge_pin_oe
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [DATA_W-1:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [PAD_W-1:0] data_q [NUM_VARIANTS];
    logic [PAD_W-1:0] data_d [NUM_VARIANTS];
    logic [NUM_VARIANTS-1:0] enable_n_q, enable_n_d;
    logic polarity_q, polarity_d;
    logic [1:0] sync_init_q, sync_init_d, sync_clr_q, sync_clr_d;
    logic [PAD_W-1:0] pad_val [NUM_VARIANTS];
    logic [PAD_W-1:0] pad_oe [NUM_VARIANTS];
    logic wr_fire, wr_err, rd_err;
    logic [2:0] wr_idx, rd_idx;
    logic [DATA_W-1:0] rd_data;
    logic init_set, init_clr;

    function automatic logic [PAD_W-1:0] merge_lanes(
        input logic [PAD_W-1:0] old,
        input logic [DATA_W-1:0] wd,
        input logic [3:0] st
    );
        logic [PAD_W-1:0] res;
        res = old;
        if (st[0]) begin
            res[7:0] = wd[7:0];
        end
        if (st[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : merge_lanes

    // ------------------------------------------------------------
    // Initialisation sources
    // ------------------------------------------------------------
    // These act asynchronously on the pad flip-flops, so they bypass the
    // synchronisers; the synchronised copies only feed the status word.
    assign init_set = (global_init == polarity_q);
    assign init_clr = init_set | ~global_clear_n;

    always_comb begin
        sync_init_d = {sync_init_q[0], global_init};
        sync_clr_d = {sync_clr_q[0], global_clear_n};
    end

    always_ff @(posedge aclk) begin
        sync_init_q <= sync_init_d;
        sync_clr_q <= sync_clr_d;
    end

    // ------------------------------------------------------------
    // Pad registers
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_VARIANTS; i++) begin : g_var
            localparam int unsigned W = VAR_WIDTH[i];
            logic [W-1:0] out_w;
            logic [W-1:0] oe_w;
            pad_capture_register #(
                .WIDTH(W),
                .NEG_EDGE(VAR_NEG_EDGE[i]),
                .PRESET(VAR_PRESET[i]),
                .HAS_TRISTATE(VAR_TRISTATE[i])
            ) u_pad (
                .clk(aclk),
                .aresetn(aresetn),
                .init_async(VAR_PRESET[i] ? init_set : init_clr),
                .data(data_q[i][W-1:0]),
                .enable_n(enable_n_q[i]),
                .pin_out(out_w),
                .pin_oe(oe_w)
            );
            assign pad_val[i] = PAD_W'(out_w);
            assign pad_oe[i] = PAD_W'(oe_w);
        end
    endgenerate

    assign preset_negedge_pin = pad_val[0][0];
    assign tri_pin_1 = pad_val[1][0];
    assign tri_pin_1_oe = pad_oe[1][0];
    assign tri_pin_4 = pad_val[2][3:0];
    assign tri_pin_4_oe = pad_oe[2][3:0];
    assign tri_pin_8 = pad_val[3][7:0];
    assign tri_pin_8_oe = pad_oe[3][7:0];
    assign tri_pin_16 = pad_val[4];
    assign tri_pin_16_oe = pad_oe[4];
    assign tri_negedge_pin = pad_val[5][0];
    assign tri_negedge_pin_oe = pad_oe[5][0];
    assign tri_preset_pin = pad_val[6][0];
    assign tri_preset_pin_oe = pad_oe[6][0];
    assign tri_preset_negedge_pin = pad_val[7][0];
    assign tri_preset_negedge_pin_oe = pad_oe[7][0];

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
    assign wr_idx = aw_addr_q[4:2];

    always_comb begin
        data_d = data_q;
        enable_n_d = enable_n_q;
        polarity_d = polarity_q;
        wr_err = 1'b0;
        if (aw_addr_q[7:5] == OFS_DATA_BASE[7:5]) begin
            if (wr_fire) begin
                data_d[wr_idx] = merge_lanes(data_q[wr_idx], w_data_q, w_strb_q)
                    & VAR_MASK[wr_idx];
            end
        end else if (aw_addr_q[7:2] == OFS_ENABLE[7:2]) begin
            if (wr_fire && w_strb_q[0]) begin
                enable_n_d = w_data_q[NUM_VARIANTS-1:0];
            end
        end else if (aw_addr_q[7:2] == OFS_CONFIG[7:2]) begin
            if (wr_fire && w_strb_q[0]) begin
                polarity_d = w_data_q[FLD_POLARITY];
            end
        end else if (aw_addr_q[7:2] != OFS_STATUS[7:2]) begin
            wr_err = 1'b1;
        end
        if (!aresetn) begin
            for (int k = 0; k < NUM_VARIANTS; k++) begin
                data_d[k] = VAR_PRESET[k] ? VAR_MASK[k] : '0;
            end
            enable_n_d = ENABLE_RST;
            polarity_d = POLARITY_RST;
        end
    end

    always_ff @(posedge aclk) begin
        data_q <= data_d;
        enable_n_q <= enable_n_d;
        polarity_q <= polarity_d;
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------
    always_comb begin
        aw_hold_d = aw_hold_q;
        aw_addr_d = aw_addr_q;
        w_hold_d = w_hold_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (awvalid && awready_q) begin
            aw_hold_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready_q) begin
            w_hold_d = 1'b1;
            w_data_d = wdata;
            w_strb_d = wstrb;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        awready_d = ~aw_hold_d & ~bvalid_d;
        wready_d = ~w_hold_d & ~bvalid_d;
        if (!aresetn) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b0;
            bresp_d = RESP_OKAY;
            awready_d = 1'b0;
            wready_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        aw_hold_q <= aw_hold_d;
        aw_addr_q <= aw_addr_d;
        w_hold_q <= w_hold_d;
        w_data_q <= w_data_d;
        w_strb_q <= w_strb_d;
        bvalid_q <= bvalid_d;
        bresp_q <= bresp_d;
        awready_q <= awready_d;
        wready_q <= wready_d;
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // ------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------
    assign rd_idx = araddr[4:2];

    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        if (araddr[7:5] == OFS_DATA_BASE[7:5]) begin
            rd_data[PAD_W-1:0] = data_q[rd_idx];
            rd_data[FLD_READBACK_LSB +: PAD_W] = pad_val[rd_idx];
        end else if (araddr[7:2] == OFS_ENABLE[7:2]) begin
            rd_data[NUM_VARIANTS-1:0] = enable_n_q;
        end else if (araddr[7:2] == OFS_CONFIG[7:2]) begin
            rd_data[FLD_POLARITY] = polarity_q;
        end else if (araddr[7:2] == OFS_STATUS[7:2]) begin
            rd_data[FLD_STS_INIT] = sync_init_q[1];
            rd_data[FLD_STS_CLEAR_N] = sync_clr_q[1];
        end else begin
            rd_err = 1'b1;
        end
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = rd_data;
            rresp_d = rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        arready_d = ~rvalid_d;
        if (!aresetn) begin
            rvalid_d = 1'b0;
            rdata_d = '0;
            rresp_d = RESP_OKAY;
            arready_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        rvalid_q <= rvalid_d;
        rdata_q <= rdata_d;
        rresp_q <= rresp_d;
        arready_q <= arready_d;
    end

    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_taken;
        awvalid && awready && wvalid && wready;
    endsequence

    sequence s_answer_held;
        bvalid && !bready ##1 bvalid && $stable(bresp);
    endsequence

    a_clear_n_clears: assert property (
        !global_clear_n |-> !tri_pin_1 && !tri_negedge_pin && tri_pin_16 == '0)
        else $error("global clear did not clear the reset-type pads");

    a_init_polarity: assert property (
        global_init == polarity_q |-> preset_negedge_pin && tri_preset_pin)
        else $error("global init at chosen level did not preset the pads");

    a_write_answer: assert property (s_write_taken |-> ##2 bvalid)
        else $error("write answer not given two cycles after the handshake");

    a_bvalid_held: assert property (bvalid && !bready |-> s_answer_held)
        else $error("write answer dropped before it was taken");

    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer not given one cycle after the address");

    a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed before it was taken");

endmodule : pad_output_register_tristate

// ==== sim/pad_board_net.sv ====
// Board-side model of the nets behind the three-state pad outputs.
// Assumes one net per pad bit and pin_oe high while the device drives it.
`timescale 1ns/10ps
module pad_board_net #(
    parameter int W = 31
) (
    input wire logic clk,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    output logic [W-1:0] net
);
    // ------------------------------------------------------------
    // Net level
    // ------------------------------------------------------------
    // The nets have no pull, so a released net toggles every cycle;
    // a stale value must never look like a driven one.
    logic [W-1:0] last_q = '0;

    always_ff @(posedge clk) begin
        last_q <= net;
    end

    always_comb begin
        net = (pin_out & pin_oe) | (~last_q & ~pin_oe);
    end
endmodule : pad_board_net

// ==== sim/pad_output_register_tristate_tb_top.sv ====
// Self-checking bench for the pad output register bank.
// Assumes the bank is reached over AXI4-Lite on a 200 MHz aclk.
`timescale 1ns/10ps
module pad_output_register_tristate_tb_top
    import pad_regs_pkg::*;
;
    typedef struct {int slot; logic [31:0] wd; logic [15:0] exp;} row_s;
    row_s rows [8] = '{'{1, 32'h0000_0001, 16'h0001}, '{2, 32'h0000_FFF5, 16'h0005},
        '{3, 32'h0000_015A, 16'h005A}, '{4, 32'hFFFF_BEEF, 16'hBEEF},
        '{0, 32'h0000_0000, 16'h0000}, '{5, 32'h0000_0001, 16'h0001},
        '{6, 32'h0000_0000, 16'h0000}, '{7, 32'h0000_0000, 16'h0000}};
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, global_init = 0, global_clear_n = 1, mon_on = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd_data;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, preset_negedge_pin;
    logic [1:0] bresp, rresp, rd_resp;
    logic [31:0] rdata;
    logic tri_pin_1, tri_pin_1_oe, tri_negedge_pin, tri_negedge_pin_oe;
    logic tri_preset_pin, tri_preset_pin_oe, tri_preset_negedge_pin, tri_preset_negedge_pin_oe;
    logic [3:0] tri_pin_4, tri_pin_4_oe;
    logic [7:0] tri_pin_8, tri_pin_8_oe;
    logic [15:0] tri_pin_16, tri_pin_16_oe;
    logic [31:0] pins, oes, net;
    logic [15:0] exp_pad [8];
    int n_mismatch = 0, total_checks = 0, cyc = 0;

    assign pins = {tri_preset_negedge_pin, tri_preset_pin, tri_negedge_pin, tri_pin_16,
        tri_pin_8, tri_pin_4, tri_pin_1};
    assign oes = {tri_preset_negedge_pin_oe, tri_preset_pin_oe, tri_negedge_pin_oe,
        tri_pin_16_oe, tri_pin_8_oe, tri_pin_4_oe, tri_pin_1_oe};

    always #2.5 aclk = ~aclk;

    pad_output_register_tristate u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .rvalid, .rready, .rdata, .rresp, .global_init, .global_clear_n,
        .preset_negedge_pin, .tri_pin_1, .tri_pin_1_oe, .tri_pin_4, .tri_pin_4_oe,
        .tri_pin_8, .tri_pin_8_oe, .tri_pin_16, .tri_pin_16_oe, .tri_negedge_pin,
        .tri_negedge_pin_oe, .tri_preset_pin, .tri_preset_pin_oe, .tri_preset_negedge_pin,
        .tri_preset_negedge_pin_oe);

    pad_board_net #(.W(32)) u_board (.clk(aclk), .pin_out(pins), .pin_oe(oes), .net(net));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask : axi_write

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge aclk);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
        chk(rd_data, exp, "read data");
        chk({30'h0, rd_resp}, {30'h0, er}, "read response");
    endtask : rd_chk

    function automatic logic [15:0] pad_of(input int i);
        case (i)
            0: return {15'h0, preset_negedge_pin};
            1: return {15'h0, tri_pin_1};
            2: return {12'h0, tri_pin_4};
            3: return {8'h0, tri_pin_8};
            4: return tri_pin_16;
            5: return {15'h0, tri_negedge_pin};
            6: return {15'h0, tri_preset_pin};
            default: return {15'h0, tri_preset_negedge_pin};
        endcase
    endfunction : pad_of

    function automatic logic [15:0] init_of(input int i);
        return VAR_PRESET[i] ? VAR_MASK[i] : 16'h0000;
    endfunction : init_of

    // Mode 0: stored data, 1: every pad at its initial value, 2: clear-type pads low.
    task automatic check_pads(input int mode);
        logic [15:0] e;
        for (int i = 0; i < 8; i++) begin
            e = exp_pad[i];
            if (mode == 1 || (mode == 2 && !VAR_PRESET[i])) e = init_of(i);
            chk({16'h0000, pad_of(i)}, {16'h0000, e}, "pad level");
        end
    endtask : check_pads

    task automatic edge_chk(input logic want, input string what);
        if (mon_on) chk({31'h0, aclk}, {31'h0, want}, what);
    endtask : edge_chk

    // ------------------------------------------------------------
    // Capture edge monitors and timeout
    // ------------------------------------------------------------
    always @(preset_negedge_pin) edge_chk(1'b0, "falling capture");
    always @(tri_negedge_pin) edge_chk(1'b0, "falling capture");
    always @(tri_preset_negedge_pin) edge_chk(1'b0, "falling capture");
    always @(tri_pin_16) edge_chk(1'b1, "rising capture");
    always @(tri_preset_pin) edge_chk(1'b1, "rising capture");

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            $display("wrong value at %0t: run did not complete", $time);
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 8; i++) exp_pad[i] = init_of(i);
        check_pads(0);
        chk(oes, 32'h0000_0000, "enable after reset");
        for (int i = 0; i < 8; i++) rd_chk(8'(4 * i), {init_of(i), init_of(i)}, RESP_OKAY);
        rd_chk(OFS_ENABLE, {24'h0, ENABLE_RST}, RESP_OKAY);
        rd_chk(OFS_CONFIG, {31'h0, POLARITY_RST}, RESP_OKAY);
        $display("test reset values done");
        mon_on = 1'b1;
        foreach (rows[k]) begin
            axi_write(8'(4 * rows[k].slot), rows[k].wd, RESP_OKAY);
            repeat (2) @(posedge aclk);
            exp_pad[rows[k].slot] = rows[k].exp;
            chk({16'h0000, pad_of(rows[k].slot)}, {16'h0000, rows[k].exp}, "pad");
            rd_chk(8'(4 * rows[k].slot), {rows[k].exp, rows[k].exp}, RESP_OKAY);
        end
        $display("test capture table done");
        axi_write(OFS_ENABLE, 32'h0000_0000, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(oes, 32'hFFFF_FFFF, "pads driven");
        chk(net, pins, "net level");
        axi_write(OFS_ENABLE, 32'h0000_00FF, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(oes, 32'h0000_0000, "pads floating");
        check_pads(0);
        mon_on = 1'b0;
        $display("test enable done");
        @(posedge aclk);
        global_init <= 1'b1;
        #1 check_pads(1);
        @(posedge aclk);
        global_init <= 1'b0;
        repeat (2) @(posedge aclk);
        check_pads(0);
        axi_write(OFS_CONFIG, 32'h0000_0000, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check_pads(1);
        global_init <= 1'b1;
        repeat (3) @(posedge aclk);
        check_pads(0);
        global_init <= 1'b0;
        axi_write(OFS_CONFIG, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check_pads(0);
        global_clear_n <= 1'b0;
        #1 check_pads(2);
        @(posedge aclk);
        global_clear_n <= 1'b1;
        repeat (2) @(posedge aclk);
        check_pads(0);
        $display("test global init done");
        rd_chk(OFS_STATUS, 32'h0000_0002, RESP_OKAY);
        axi_write(OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        axi_write(8'h2C, 32'h0000_0001, RESP_SLVERR);
        rd_chk(8'h2C, 32'h0000_0000, RESP_SLVERR);
        // Lane 1 strobe off: only the low byte of the wide pad may change.
        wstrb <= 4'h1;
        axi_write(8'h10, 32'h0000_1234, RESP_OKAY);
        wstrb <= 4'hF;
        rd_chk(8'h10, 32'hBE34_BE34, RESP_OKAY);
        $display("test bus errors done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        for (int i = 0; i < 8; i++) exp_pad[i] = init_of(i);
        check_pads(0);
        chk(oes, 32'h0000_0000, "enable in reset");
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(8'h10, 32'h0000_0000, RESP_OKAY);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : pad_output_register_tristate_tb_top
